// ### shared/nco_readback_pkg.sv
// Package: offsets, widths and reset values of the oscillator readback registers
package nco_readback_pkg;

  // Oscillator count and word widths
  localparam int NUM_NCO = 4;
  localparam int FREQ_W = 64;
  localparam int PHASE_W = 16;
  localparam int ACCUM_W = 32;
  localparam int ADDR_W = 15;

  // Byte offsets of the readback groups
  localparam logic [ADDR_W-1:0] FREQ_IN_USE_BASE = 15'h0380;
  localparam logic [ADDR_W-1:0] NCO0_FREQUENCY_IN_USE = 15'h0380;
  localparam logic [ADDR_W-1:0] NCO1_FREQUENCY_IN_USE = 15'h0388;
  localparam logic [ADDR_W-1:0] NCO2_FREQUENCY_IN_USE = 15'h0390;
  localparam logic [ADDR_W-1:0] NCO3_FREQUENCY_IN_USE = 15'h0398;
  localparam logic [ADDR_W-1:0] PHASE_IN_USE_BASE = 15'h03a0;
  localparam logic [ADDR_W-1:0] NCO0_PHASE_IN_USE = 15'h03a0;
  localparam logic [ADDR_W-1:0] NCO1_PHASE_IN_USE = 15'h03a2;
  localparam logic [ADDR_W-1:0] NCO2_PHASE_IN_USE = 15'h03a4;
  localparam logic [ADDR_W-1:0] NCO3_PHASE_IN_USE = 15'h03a6;
  localparam logic [ADDR_W-1:0] FAST_RECONFIG_SYNC_LAST = 15'h03e0;

  // Field position of the sync flag in its register
  localparam int FAST_RECONFIG_SYNC_BIT_POS = 7;

  // Reset values
  localparam logic [PHASE_W-1:0] PHASE_RESET = 16'h0000;
  localparam logic [7:0] READ_DATA_RESET = 8'h00;

endpackage

// ### shared/phase_update_if.sv
// Interface: phase setting path between the register block and the phase hold stage
interface phase_update_if;
  import nco_readback_pkg::*;

  logic [NUM_NCO-1:0] wrStb;
  logic [PHASE_W-1:0] wrData;
  logic [NUM_NCO-1:0] syncEvent;
  logic [NUM_NCO-1:0][PHASE_W-1:0] inUse;
  logic [NUM_NCO-1:0][ACCUM_W-1:0] accumOffset;

  modport ctrl (
    output wrStb,
    output wrData,
    output syncEvent,
    input inUse,
    input accumOffset
  );

  modport stage (
    input wrStb,
    input wrData,
    input syncEvent,
    output inUse,
    output accumOffset
  );
endinterface

// ### rtl/nco_phase_hold.sv
// Holds written phase settings until each oscillator's sync event, then applies them
module nco_phase_hold
  import nco_readback_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Phase path
  phase_update_if.stage ph
);

  logic [NUM_NCO-1:0][PHASE_W-1:0] pending_reg;
  logic [NUM_NCO-1:0][PHASE_W-1:0] inUse_reg;

  for (genvar n = 0; n < NUM_NCO; n++) begin : g_nco
    // A write waits here; a write in the same cycle as an event waits for the next one
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        pending_reg[n] <= PHASE_RESET;
      end else if (ph.wrStb[n]) begin
        pending_reg[n] <= ph.wrData;
      end
    end

    // Operating value changes only on the selected sync event
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        inUse_reg[n] <= PHASE_RESET;
      end else if (ph.syncEvent[n]) begin
        inUse_reg[n] <= pending_reg[n];
      end
    end

    // Left justified into the accumulator field: the word is a fraction of a turn
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        ph.accumOffset[n] <= {ACCUM_W{1'b0}};
      end else if (ph.syncEvent[n]) begin
        ph.accumOffset[n] <= {pending_reg[n], {(ACCUM_W-PHASE_W){1'b0}}};
      end
    end

    assign ph.inUse[n] = inUse_reg[n];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_phase_held;
    @(posedge clk) disable iff (!nrst)
    !ph.syncEvent[0] |=> $stable(ph.inUse[0]);
  endproperty
  a_phase_held: assert property (p_phase_held)
    else $error("phase in use changed without a sync event");

  property p_phase_applied;
    @(posedge clk) disable iff (!nrst)
    (ph.wrStb[1] && !ph.syncEvent[1]) ##1 (ph.syncEvent[1] && !ph.wrStb[1])
      |=> ph.inUse[1] == $past(ph.wrData, 2);
  endproperty
  a_phase_applied: assert property (p_phase_applied)
    else $error("written phase not applied at the following sync event");

  property p_accum_justified;
    @(posedge clk) disable iff (!nrst)
    ph.syncEvent[2] |=> ph.accumOffset[2] == {ph.inUse[2], 16'h0000};
  endproperty
  a_accum_justified: assert property (p_accum_justified)
    else $error("accumulator phase field not left justified");

endmodule // nco_phase_hold

// ### rtl/nco_setting_readback_regs.sv
// Readback registers for oscillator frequency, phase and fast reconfiguration sync
//
// Functional notes
// - Each of four oscillators returns its full 64-bit frequency in use.
// - Every byte read samples the live value; multi-byte reads may mix.
// - Each of four oscillators returns its 16-bit phase word in use.
// - Bit 7 of an 8-bit register shows last fast-port sync flag.
// - Phase word goes to the upper half of a 32-bit accumulator field.
// - A new phase setting takes effect only at the next sync event.
module nco_setting_readback_regs
  import nco_readback_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port from the serial control interface
  input wire logic regRdEn,
  input wire logic regWrEn,
  input wire logic [ADDR_W-1:0] regAddr,
  output logic [7:0] regRdData,
  output logic regAck,
  // Datapath operating values
  input wire logic [NUM_NCO-1:0][FREQ_W-1:0] freqInUse,
  // Phase setting path
  input wire logic [NUM_NCO-1:0] phaseWrEn,
  input wire logic [PHASE_W-1:0] phaseWrData,
  input wire logic [NUM_NCO-1:0] ncoSyncEvent,
  output logic [NUM_NCO-1:0][ACCUM_W-1:0] phaseAccumOffset,
  // Fast reconfiguration port
  input wire logic fastReconfigSyncBit
);

  phase_update_if phIf ();

  logic [7:0] rdByte;
  logic [7:0] regRdData_reg;
  logic regAck_reg;
  logic [NUM_NCO-1:0][ACCUM_W-1:0] phaseAccumOffset_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Phase hold stage

  assign phIf.wrStb = phaseWrEn;
  assign phIf.wrData = phaseWrData;
  assign phIf.syncEvent = ncoSyncEvent;

  nco_phase_hold u_phase_hold (
    .clk (clk),
    .nrst (nrst),
    .ph (phIf.stage)
  );

  // Re-registered so the top output leaves straight from a flip-flop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phaseAccumOffset_reg <= '0;
    end else begin
      phaseAccumOffset_reg <= phIf.accumOffset;
    end
  end

  assign phaseAccumOffset = phaseAccumOffset_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Read decode

  // Byte lane picked from the live value, lowest offset holds the least byte
  always_comb begin
    rdByte = 8'h00;
    for (int n = 0; n < NUM_NCO; n++) begin
      if (regAddr[ADDR_W-1:3] == FREQ_IN_USE_BASE[ADDR_W-1:3] + n[ADDR_W-4:0]) begin
        rdByte = freqInUse[n][regAddr[2:0]*8 +: 8];
      end
      if (regAddr[ADDR_W-1:1] == PHASE_IN_USE_BASE[ADDR_W-1:1] + n[ADDR_W-2:0]) begin
        rdByte = phIf.inUse[n][regAddr[0]*8 +: 8];
      end
    end
    // Not synchronised: stable only while the fast port is idle
    if (regAddr == FAST_RECONFIG_SYNC_LAST) begin
      rdByte = 8'h00;
      rdByte[FAST_RECONFIG_SYNC_BIT_POS] = fastReconfigSyncBit;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data and answer

  // Each byte is sampled when its own read arrives, so wide words may tear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdData_reg <= READ_DATA_RESET;
    end else if (regRdEn) begin
      regRdData_reg <= rdByte;
    end
  end

  // Writes are answered but change nothing
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regAck_reg <= 1'b0;
    end else begin
      regAck_reg <= regRdEn | regWrEn;
    end
  end

  assign regRdData = regRdData_reg;
  assign regAck = regAck_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_freq3_top;
    @(posedge clk) disable iff (!nrst)
    (regRdEn && regAddr == NCO3_FREQUENCY_IN_USE + 15'h0007)
      |=> regRdData == $past(freqInUse[3][63:56]);
  endproperty
  a_freq3_top: assert property (p_freq3_top)
    else $error("top byte of oscillator 3 frequency wrong");

  property p_freq0_low;
    @(posedge clk) disable iff (!nrst)
    (regRdEn && regAddr == NCO0_FREQUENCY_IN_USE)
      |=> regRdData == $past(freqInUse[0][7:0]);
  endproperty
  a_freq0_low: assert property (p_freq0_low)
    else $error("low byte of oscillator 0 frequency wrong");

  property p_byte_sampled;
    @(posedge clk) disable iff (!nrst)
    (regRdEn && regAddr == NCO2_FREQUENCY_IN_USE + 15'h0002)
      ##1 (regRdEn && regAddr == NCO2_FREQUENCY_IN_USE + 15'h0003)
      |=> regRdData == $past(freqInUse[2][31:24]);
  endproperty
  a_byte_sampled: assert property (p_byte_sampled)
    else $error("byte not sampled at its own read");

  property p_phase1_high;
    @(posedge clk) disable iff (!nrst)
    (regRdEn && regAddr == NCO1_PHASE_IN_USE + 15'h0001)
      |=> regRdData == $past(phIf.inUse[1][15:8]);
  endproperty
  a_phase1_high: assert property (p_phase1_high)
    else $error("high byte of oscillator 1 phase wrong");

  property p_sync_flag;
    @(posedge clk) disable iff (!nrst)
    (regRdEn && regAddr == FAST_RECONFIG_SYNC_LAST)
      |=> regRdData == {$past(fastReconfigSyncBit), 7'h00};
  endproperty
  a_sync_flag: assert property (p_sync_flag)
    else $error("sync flag register content wrong");

  property p_write_inert;
    @(posedge clk) disable iff (!nrst)
    (regWrEn && !regRdEn) |=> regAck && $stable(regRdData);
  endproperty
  a_write_inert: assert property (p_write_inert)
    else $error("register write disturbed read data");

  property p_unmapped_zero;
    @(posedge clk) disable iff (!nrst)
    (regRdEn && regAddr == 15'h03e1) |=> regRdData == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");

  property p_offset_follows;
    @(posedge clk) disable iff (!nrst)
    ncoSyncEvent[3] |-> ##2 phaseAccumOffset[3][31:16] == $past(phIf.inUse[3]);
  endproperty
  a_offset_follows: assert property (p_offset_follows)
    else $error("accumulator offset does not follow phase in use");

  property p_ack_timing;
    @(posedge clk) disable iff (!nrst)
    regRdEn |=> regAck;
  endproperty
  a_ack_timing: assert property (p_ack_timing)
    else $error("read not answered in one cycle");

endmodule // nco_setting_readback_regs

// ### verification/nco_setting_readback_regs_tb_top.sv
// Testbench: self-checking scenarios for the oscillator readback register block
module nco_setting_readback_regs_tb_top
  import nco_readback_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, nrst, regRdEn, regWrEn, regAck, fastReconfigSyncBit;
  logic [ADDR_W-1:0] regAddr;
  logic [7:0] regRdData;
  logic [NUM_NCO-1:0][FREQ_W-1:0] freqInUse;
  logic [NUM_NCO-1:0] phaseWrEn, ncoSyncEvent;
  logic [PHASE_W-1:0] phaseWrData;
  logic [NUM_NCO-1:0][ACCUM_W-1:0] phaseAccumOffset;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////////////
  nco_setting_readback_regs dut_u (.clk(clk), .nrst(nrst), .regRdEn(regRdEn),
    .regWrEn(regWrEn), .regAddr(regAddr), .regRdData(regRdData), .regAck(regAck),
    .freqInUse(freqInUse), .phaseWrEn(phaseWrEn), .phaseWrData(phaseWrData),
    .ncoSyncEvent(ncoSyncEvent), .phaseAccumOffset(phaseAccumOffset),
    .fastReconfigSyncBit(fastReconfigSyncBit));
  // Clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail = n_fail + 1;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(string what, logic [63:0] e, logic [63:0] s);
    check_count = check_count + 1;
    if (s !== e) begin
      $display("mismatch %s expected %h seen %h", what, e, s);
      n_fail = n_fail + 1;
    end
  endtask
  // One byte access; answer is looked at in its single ack cycle
  task automatic access(logic wr, logic [ADDR_W-1:0] a, logic [7:0] e);
    @(posedge clk) #1;
    regRdEn = ~wr;
    regWrEn = wr;
    regAddr = a;
    @(posedge clk) #1;
    regRdEn = 1'b0;
    regWrEn = 1'b0;
    chk("regAck", 64'h1, {63'h0, regAck});
    if (!wr) chk("regRdData", {56'h0, e}, {56'h0, regRdData});
  endtask
  // Pulse phase write and/or sync strobes for one cycle
  task automatic phase_op(logic [3:0] wr, logic [3:0] sy, logic [15:0] d);
    @(posedge clk) #1;
    phaseWrEn = wr;
    ncoSyncEvent = sy;
    phaseWrData = d;
    @(posedge clk) #1;
    phaseWrEn = 4'h0;
    ncoSyncEvent = 4'h0;
  endtask
  task automatic rd_phase(int n, logic [15:0] e);
    access(1'b0, ADDR_W'(NCO0_PHASE_IN_USE + 2 * n), e[7:0]);
    access(1'b0, ADDR_W'(NCO0_PHASE_IN_USE + 2 * n + 1), e[15:8]);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Every byte of every frequency word, little end first
  task automatic test_freq();
    for (int n = 0; n < NUM_NCO; n++) begin
      for (int k = 0; k < 8; k++) begin
        access(1'b0, ADDR_W'(NCO0_FREQUENCY_IN_USE + 8 * n + k), freqInUse[n][8*k+:8]);
      end
    end
  endtask
  // A value change between byte reads shows up in the later byte only
  task automatic test_mixed();
    access(1'b0, NCO2_FREQUENCY_IN_USE, freqInUse[2][7:0]);
    freqInUse[2] = 64'hffee_ddcc_bbaa_9988;
    access(1'b0, ADDR_W'(NCO2_FREQUENCY_IN_USE + 1), 8'h99);
  endtask
  // Back-to-back byte reads; the word changes between them, so bytes come from two values
  task automatic test_back_to_back();
    @(posedge clk) #1;
    regRdEn = 1'b1;
    regAddr = ADDR_W'(NCO2_FREQUENCY_IN_USE + 2);
    @(posedge clk) #1;
    regAddr = ADDR_W'(NCO2_FREQUENCY_IN_USE + 3);
    freqInUse[2] = 64'h0000_0000_7766_5544;
    chk("regAck", 64'h1, {63'h0, regAck});
    chk("regRdData", 64'haa, {56'h0, regRdData});
    @(posedge clk) #1;
    regRdEn = 1'b0;
    chk("regAck", 64'h1, {63'h0, regAck});
    chk("regRdData", 64'h77, {56'h0, regRdData});
  endtask
  // Write then sync on the very next cycle: the fresh value goes into use
  task automatic test_wr_sync();
    @(posedge clk) #1;
    phaseWrEn = 4'h2;
    phaseWrData = 16'h1234;
    @(posedge clk) #1;
    phaseWrEn = 4'h0;
    ncoSyncEvent = 4'h2;
    @(posedge clk) #1;
    ncoSyncEvent = 4'h0;
    @(posedge clk) #1;
    chk("phaseAccumOffset", 64'h1234_0000, {32'h0, phaseAccumOffset[1]});
    rd_phase(1, 16'h1234);
  endtask
  // Held until sync; a write coinciding with sync waits for the next one
  task automatic test_phase();
    for (int n = 0; n < NUM_NCO; n++) begin
      phase_op(4'(1 << n), 4'h0, 16'h8001 + 16'(n));
      rd_phase(n, 16'h0000);
      phase_op(4'h0, 4'(1 << n), 16'h0000);
      @(posedge clk) #1;
      chk("phaseAccumOffset", {16'h8001 + 16'(n), 16'h0000}, phaseAccumOffset[n]);
      rd_phase(n, 16'h8001 + 16'(n));
    end
    phase_op(4'h2, 4'h2, 16'h5a5a);
    rd_phase(1, 16'h8002);
    phase_op(4'h0, 4'h2, 16'h0000);
    rd_phase(1, 16'h5a5a);
  endtask
  // Sync flag in bit 7, writes inert, unmapped read zero
  task automatic test_misc();
    fastReconfigSyncBit = 1'b1;
    access(1'b0, FAST_RECONFIG_SYNC_LAST, 8'h80);
    fastReconfigSyncBit = 1'b0;
    access(1'b0, FAST_RECONFIG_SYNC_LAST, 8'h00);
    access(1'b1, NCO0_PHASE_IN_USE, 8'h00);
    access(1'b1, FAST_RECONFIG_SYNC_LAST, 8'h00);
    rd_phase(0, 16'h8001);
    access(1'b0, 15'h03e8, 8'h00);
    access(1'b0, 15'h03e1, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    nrst = 1'b0;
    regRdEn = 1'b0;
    regWrEn = 1'b0;
    regAddr = 15'h0000;
    phaseWrEn = 4'h0;
    ncoSyncEvent = 4'h0;
    phaseWrData = 16'h0000;
    fastReconfigSyncBit = 1'b0;
    for (int n = 0; n < NUM_NCO; n++) freqInUse[n] = 64'h0123_4567_89ab_cd00 + 64'(n * 17);
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
    chk("regAck", 64'h0, {63'h0, regAck});
    chk("phaseAccumOffset", 64'h0, {32'h0, phaseAccumOffset[0]});
    test_freq();
    test_mixed();
    test_back_to_back();
    test_phase();
    test_wr_sync();
    test_misc();
    test_done();
  end
endmodule // nco_setting_readback_regs_tb_top
